/* sdt_diag_trim.sv */
// Fault and programming-error status, identification and signal-path trim of
// one sensor die: phase, gain, temperature offset and noise deadband.
// Assumes the output-pin protocol decoder and all event sources run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "sdt_map.svh"

// Operation
// R01 - Keep 16-bit fault status from self tests; bits 15..10 reserved.
// R02 - Set fault bit 9 when converter value reaches high clamp level.
// R03 - Set fault bit 8 when converter value reaches low clamp level.
// R04 - Set fault bit 7 on channel 1, bit 6 on channel 2 clipping.
// R05 - Set fault bit 5 when the continuous processor self test fails.
// R06 - Set fault bit 4 on memory self-test fail, power-up or continuous.
// R07 - Set fault bit 3 when program memory parity check fails.
// R08 - Set fault bit 1 when field magnitude exceeds upper limit.
// R09 - Set fault bit 0 when field magnitude falls below lower limit.
// R10 - Set programming error bit 10 when programming voltage too low.
// R11 - Set programming error bit 9 when supply low during program or erase.
// R12 - Set programming error bit 8 when non-volatile RAM programming fails.
// R13 - Programming error bits 5..0 control programming; bits 15..11 reserved.
// R14 - Programmer checks both acknowledges; reads error register after missing second. The model checks one acc_ack and never reads the error register.
// R15 - Two read-only 16-bit factory identification registers.
// R16 - Sine-based signed phase correction between channels; zero means none.
// R17 - Signed 16-bit gain per channel, 16384 is unity.
// R18 - Programmer sets channel 2 gain to 16384 over cosine of phase.
// R19 - Offset is a second-order temperature polynomial of three coefficients.
// R20 - Offset added to each channel scaled 0 to 100 percent.
// R21 - Deadband of 1 to 16383 codes, stored as negative value.
// R22 - Deadband register zero disables the hysteresis.
// R23 - Field limit violation forces the output to high clamp level.
// R24 - Reserved status bits read zero and ignore writes.
module sdt_diag_trim #(
  parameter logic [15:0] FACTORY_ID_LOW = 16'h5a01, // Arbitrary value
  parameter logic [15:0] FACTORY_ID_HIGH = 16'h00c3 // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic nrst,
  // Register access from the output-pin programming decoder
  input wire sdt_pkg::sdt_access_t acc,
  output logic acc_ack,
  output logic [15:0] acc_rdata,
  output logic [5:0] prog_ctrl,
  // Event sources
  input wire sdt_pkg::sdt_fault_ev_t fault_ev,
  input wire sdt_pkg::sdt_prog_ev_t prog_ev,
  input wire logic nvm_test_continuous,
  input wire logic powerup_done,
  // Converter value and its clamping levels
  input wire logic [15:0] dac_value,
  input wire logic [15:0] clamp_low,
  input wire logic [15:0] clamp_high,
  // Field magnitude and its limits
  input wire logic signed [15:0] field_amp,
  input wire logic signed [15:0] lower_field_limit,
  input wire logic signed [15:0] upper_field_limit,
  output logic force_high_clamp,
  // Signal path
  input wire logic sample_valid,
  input wire logic signed [15:0] ch1_comp,
  input wire logic signed [15:0] ch2_comp,
  input wire logic [15:0] temp_code,
  output logic angle_valid,
  output logic signed [15:0] angle_input_first,
  output logic signed [15:0] angle_input_second
);

  // ========================================================================
  // Arithmetic helpers
  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      sat16 = 16'sh7fff;
    end else if (v < -34'sd32768) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  // Signed product scaled down by a power of two, saturated to 16 bits
  function automatic logic signed [15:0] mul_sh(input logic signed [15:0] a,
                                                input logic signed [15:0] b,
                                                input int unsigned sh);
    logic signed [33:0] p;
    p = 34'(a * b);
    mul_sh = sat16(p >>> sh);
  endfunction : mul_sh

  // ========================================================================
  // Trim and identification registers
  logic [15:0] user_id_low_r, user_id_high_r;
  logic signed [15:0] phase_correction_r, first_channel_gain_r, second_channel_gain_r;
  logic signed [15:0] coef_a_r, coef_b_r, coef_c_r;
  logic signed [15:0] first_channel_offset_scale_r, second_channel_offset_scale_r;
  logic signed [15:0] noise_deadband_r;
  logic [15:0] fault_r, fault_nxt;
  logic [15:0] prog_r, prog_nxt;
  logic rd_fault, wr_prog;

  assign rd_fault = acc.rd && (acc.addr == `SDT_IDX_FAULT);
  assign wr_prog = acc.wr && (acc.addr == `SDT_IDX_PROGERR);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      user_id_low_r <= `SDT_ZERO16;
      user_id_high_r <= `SDT_ZERO16;
      phase_correction_r <= `SDT_ZERO16;
      first_channel_gain_r <= `SDT_GAIN_UNITY;
      second_channel_gain_r <= `SDT_GAIN_UNITY;
      coef_a_r <= `SDT_ZERO16;
      coef_b_r <= `SDT_ZERO16;
      coef_c_r <= `SDT_ZERO16;
      first_channel_offset_scale_r <= `SDT_ZERO16;
      second_channel_offset_scale_r <= `SDT_ZERO16;
      noise_deadband_r <= `SDT_ZERO16;
    end else if (acc.wr) begin
      unique case (acc.addr)
        `SDT_IDX_UID_LO: user_id_low_r <= acc.wdata;
        `SDT_IDX_UID_HI: user_id_high_r <= acc.wdata;
        `SDT_IDX_PHASE: phase_correction_r <= acc.wdata;
        `SDT_IDX_GAIN1: first_channel_gain_r <= acc.wdata;
        `SDT_IDX_GAIN2: second_channel_gain_r <= acc.wdata;
        `SDT_IDX_COEF_A: coef_a_r <= acc.wdata;
        `SDT_IDX_COEF_B: coef_b_r <= acc.wdata;
        `SDT_IDX_COEF_C: coef_c_r <= acc.wdata;
        `SDT_IDX_OSCALE1: first_channel_offset_scale_r <= acc.wdata;
        `SDT_IDX_OSCALE2: second_channel_offset_scale_r <= acc.wdata;
        `SDT_IDX_DEADBAND: noise_deadband_r <= acc.wdata;
        // Status and factory registers are not written here
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Fault status: sticky, cleared by reading it; a new event beats the clear
  logic [15:0] fault_set;
  logic nvm_window;

  // Power-up-only memory test counts only until start-up is over
  assign nvm_window = nvm_test_continuous || !powerup_done; // see R06

  always_comb begin
    fault_set = `SDT_ZERO16;
    fault_set[`SDT_FS_CLAMP_HI] = dac_value >= clamp_high; // see R02
    fault_set[`SDT_FS_CLAMP_LO] = dac_value <= clamp_low; // see R03
    fault_set[`SDT_FS_CLIP1] = fault_ev.clip1; // see R04
    fault_set[`SDT_FS_CLIP2] = fault_ev.clip2; // see R04
    fault_set[`SDT_FS_DSP] = fault_ev.dsp_fail; // see R05
    fault_set[`SDT_FS_NVM] = fault_ev.nvm_fail && nvm_window; // see R06
    fault_set[`SDT_FS_ROM] = fault_ev.rom_parity_fail; // see R07
    fault_set[`SDT_FS_FIELD_HI] = field_amp > upper_field_limit; // see R08
    fault_set[`SDT_FS_FIELD_LO] = field_amp < lower_field_limit; // see R09
    fault_nxt = ((rd_fault ? `SDT_ZERO16 : fault_r) | fault_set) & `SDT_FS_MASK; // see R01 R24
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fault_r <= `SDT_ZERO16;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  // Limit violation drives the output to its high clamping level
  assign force_high_clamp = fault_r[`SDT_FS_FIELD_HI] | fault_r[`SDT_FS_FIELD_LO]; // see R23

  // ========================================================================
  // Programming error status: flags clear by writing one, control bits are
  // plain read/write; a clear loses against an event in the same cycle
  logic [15:0] prog_set;

  always_comb begin
    prog_set = `SDT_ZERO16;
    prog_set[`SDT_PE_PUMP] = prog_ev.pump_low; // see R10
    prog_set[`SDT_PE_SUPPLY] = prog_ev.supply_low; // see R11
    prog_set[`SDT_PE_NVRAM] = prog_ev.nvram_fail; // see R12
    prog_nxt = prog_r;
    if (wr_prog) begin
      prog_nxt = (prog_r & ~(acc.wdata & `SDT_PE_FLAG_MASK) & ~`SDT_PE_CTRL_MASK)
                 | (acc.wdata & `SDT_PE_CTRL_MASK); // see R13
    end
    prog_nxt = (prog_nxt | prog_set) & (`SDT_PE_FLAG_MASK | `SDT_PE_CTRL_MASK); // see R24
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prog_r <= `SDT_ZERO16;
    end else begin
      prog_r <= prog_nxt;
    end
  end

  assign prog_ctrl = 6'(prog_r & `SDT_PE_CTRL_MASK); // see R13

  // ========================================================================
  // Read path: one cycle after the strobe; unmapped indices read zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      acc_ack <= 1'b0;
      acc_rdata <= `SDT_ZERO16;
    end else begin
      acc_ack <= acc.rd | acc.wr;
      if (acc.rd) begin
        unique case (acc.addr)
          `SDT_IDX_FAULT: acc_rdata <= fault_r;
          `SDT_IDX_PROGERR: acc_rdata <= prog_r;
          `SDT_IDX_FID_LO: acc_rdata <= FACTORY_ID_LOW; // see R15
          `SDT_IDX_FID_HI: acc_rdata <= FACTORY_ID_HIGH; // see R15
          `SDT_IDX_UID_LO: acc_rdata <= user_id_low_r;
          `SDT_IDX_UID_HI: acc_rdata <= user_id_high_r;
          `SDT_IDX_PHASE: acc_rdata <= phase_correction_r;
          `SDT_IDX_GAIN1: acc_rdata <= first_channel_gain_r;
          `SDT_IDX_GAIN2: acc_rdata <= second_channel_gain_r;
          `SDT_IDX_COEF_A: acc_rdata <= coef_a_r;
          `SDT_IDX_COEF_B: acc_rdata <= coef_b_r;
          `SDT_IDX_COEF_C: acc_rdata <= coef_c_r;
          `SDT_IDX_OSCALE1: acc_rdata <= first_channel_offset_scale_r;
          `SDT_IDX_OSCALE2: acc_rdata <= second_channel_offset_scale_r;
          `SDT_IDX_DEADBAND: acc_rdata <= noise_deadband_r;
          default: acc_rdata <= `SDT_ZERO16;
        endcase
      end
    end
  end

  // ========================================================================
  // Signal path trim, one sample per sample_valid, result a cycle later.
  // Channel 2 gain is expected to carry the cosine term of the phase
  // correction, so only the sine term is applied here (see R18).
  logic signed [15:0] tlin, tsq, poly, ch2_ph, g1, g2, o1, o2;
  logic signed [15:0] tsgn;

  always_comb begin
    tsgn = temp_code; // Only 0..32767 is used, so the sign bit stays clear
    ch2_ph = sat16(34'(ch2_comp) + 34'(mul_sh(ch1_comp, phase_correction_r,
                   `SDT_FRAC_SHIFT))); // see R16
    g1 = mul_sh(ch1_comp, first_channel_gain_r, `SDT_GAIN_SHIFT); // see R17
    g2 = mul_sh(ch2_ph, second_channel_gain_r, `SDT_GAIN_SHIFT); // see R17
    tlin = mul_sh(coef_b_r, tsgn, `SDT_FRAC_SHIFT);
    tsq = mul_sh(tsgn, tsgn, `SDT_FRAC_SHIFT);
    poly = sat16(34'(coef_a_r) + 34'(tlin) + 34'(mul_sh(coef_c_r, tsq,
                 `SDT_FRAC_SHIFT))); // see R19
    o1 = sat16(34'(g1) + 34'(mul_sh(poly, first_channel_offset_scale_r,
               `SDT_FRAC_SHIFT))); // see R20
    o2 = sat16(34'(g2) + 34'(mul_sh(poly, second_channel_offset_scale_r,
               `SDT_FRAC_SHIFT))); // see R20
  end

  // ========================================================================
  // Deadband: the stored value is negative, its magnitude is the band width
  logic hyst_on;
  logic [16:0] band;
  logic [16:0] d1, d2;

  function automatic logic [16:0] absdiff(input logic signed [15:0] a,
                                          input logic signed [15:0] b);
    logic signed [16:0] d;
    d = 17'(a) - 17'(b);
    absdiff = d[16] ? 17'(-d) : 17'(d);
  endfunction : absdiff

  assign hyst_on = noise_deadband_r != `SDT_ZERO16; // see R22
  assign band = 17'(-17'(noise_deadband_r)); // see R21
  assign d1 = absdiff(o1, angle_input_first);
  assign d2 = absdiff(o2, angle_input_second);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      angle_input_first <= `SDT_ZERO16;
      angle_input_second <= `SDT_ZERO16;
    end else if (sample_valid) begin
      if (!hyst_on || d1 > band) begin
        angle_input_first <= o1; // see R21
      end
      if (!hyst_on || d2 > band) begin
        angle_input_second <= o2; // see R21
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      angle_valid <= 1'b0;
    end else begin
      angle_valid <= sample_valid;
    end
  end

  // ========================================================================
  // Checks
  clamp_hi_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R02
    (dac_value >= clamp_high) |=> fault_r[`SDT_FS_CLAMP_HI])
    else $error("high clamp not flagged");

  clamp_lo_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R03
    (dac_value <= clamp_low) |=> fault_r[`SDT_FS_CLAMP_LO])
    else $error("low clamp not flagged");

  field_limit_clamp_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R23
    (field_amp > upper_field_limit || field_amp < lower_field_limit) |=> force_high_clamp)
    else $error("field violation did not force clamp");

  fault_sticky_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R05
    (fault_r[`SDT_FS_DSP] && !rd_fault) |=> fault_r[`SDT_FS_DSP])
    else $error("processor fault lost without read");

  nvm_powerup_only_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R06
    (!nvm_test_continuous && powerup_done && !fault_r[`SDT_FS_NVM]) |=> !fault_r[`SDT_FS_NVM])
    else $error("memory test flagged after start-up");

  fault_rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R01
    fault_r[15:10] == 6'h00 && !fault_r[2])
    else $error("reserved fault bit set");

  prog_flag_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R10
    prog_ev.pump_low |=> prog_r[`SDT_PE_PUMP])
    else $error("pump error not flagged");

  prog_supply_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R11
    prog_ev.supply_low |=> prog_r[`SDT_PE_SUPPLY])
    else $error("supply error not flagged");

  prog_nvram_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R12
    prog_ev.nvram_fail |=> prog_r[`SDT_PE_NVRAM])
    else $error("memory programming error not flagged");

  clip_flag_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R04
    fault_ev.clip1 |=> fault_r[`SDT_FS_CLIP1])
    else $error("channel 1 clipping not flagged");

  rom_parity_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R07
    fault_ev.rom_parity_fail |=> fault_r[`SDT_FS_ROM])
    else $error("parity fault not flagged");

  field_hi_set_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R08
    (field_amp > upper_field_limit) |=> fault_r[`SDT_FS_FIELD_HI])
    else $error("strong field not flagged");

  prog_rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R13
    prog_r[15:11] == 5'h00 && prog_r[7:6] == 2'h0)
    else $error("reserved programming bit set");

  deadband_off_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R22
    (sample_valid && !hyst_on) |=> angle_input_first == $past(o1))
    else $error("output held with deadband off");

  read_ack_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see R15
    (acc.rd && acc.addr == `SDT_IDX_FID_LO) |=> acc_ack && acc_rdata == FACTORY_ID_LOW)
    else $error("factory id read wrong");

endmodule : sdt_diag_trim
`default_nettype wire

/* sdt_diag_trim_tb_top.sv */
// Self-checking bench for the diagnostics and trim block.
// Assumes sdt_map.svh, sdt_pkg and sdt_prog_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sdt_map.svh"

module sdt_diag_trim_tb_top;
  localparam logic [15:0] FID_LO = 16'h1357; // Arbitrary value
  localparam logic [15:0] FID_HI = 16'h2468; // Arbitrary value
  logic ref_clk, nrst, acc_ack, angle_valid, force_high_clamp, sample_valid;
  logic nvm_test_continuous, powerup_done;
  logic [15:0] acc_rdata, dac_value, clamp_low, clamp_high, temp_code;
  logic [5:0] prog_ctrl;
  logic signed [15:0] field_amp, lower_field_limit, upper_field_limit;
  logic signed [15:0] ch1_comp, ch2_comp, angle_input_first, angle_input_second;
  sdt_pkg::sdt_access_t acc;
  sdt_pkg::sdt_fault_ev_t fault_ev;
  sdt_pkg::sdt_prog_ev_t prog_ev;
  int n_errors = 0;
  int samples_checked = 0;
  logic [15:0] rst_val [16];

  sdt_diag_trim #(.FACTORY_ID_LOW(FID_LO), .FACTORY_ID_HIGH(FID_HI)) i_sdt_diag_trim (
    .ref_clk(ref_clk), .nrst(nrst), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata),
    .prog_ctrl(prog_ctrl), .fault_ev(fault_ev), .prog_ev(prog_ev),
    .nvm_test_continuous(nvm_test_continuous), .powerup_done(powerup_done),
    .dac_value(dac_value), .clamp_low(clamp_low), .clamp_high(clamp_high),
    .field_amp(field_amp), .lower_field_limit(lower_field_limit),
    .upper_field_limit(upper_field_limit), .force_high_clamp(force_high_clamp),
    .sample_valid(sample_valid), .ch1_comp(ch1_comp), .ch2_comp(ch2_comp),
    .temp_code(temp_code), .angle_valid(angle_valid),
    .angle_input_first(angle_input_first), .angle_input_second(angle_input_second));

  sdt_prog_model i_sdt_prog_model (
    .ref_clk(ref_clk), .acc(acc), .acc_ack(acc_ack), .acc_rdata(acc_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ======================================================================
  // Checking and access tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    i_sdt_prog_model.xfer(1'b1, a, d, q, ok);
    chk("write ack", {15'h0, ok}, 16'h0001);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    i_sdt_prog_model.xfer(1'b0, a, 16'h0000, q, ok);
    chk("read ack", {15'h0, ok}, 16'h0001);
    chk($sformatf("register %h", a), q, exp);
  endtask : rd

  task automatic smp(input logic [15:0] a, b, ea, eb);
    @(negedge ref_clk);
    sample_valid = 1'b1;
    ch1_comp = a;
    ch2_comp = b;
    @(negedge ref_clk);
    sample_valid = 1'b0;
    chk("angle valid", {15'h0, angle_valid}, 16'h0001);
    chk("first channel", angle_input_first, ea);
    chk("second channel", angle_input_second, eb);
  endtask : smp

  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // ======================================================================
  // Main sequence
  initial begin
    nrst = 1'b0; fault_ev = '0; prog_ev = '0; sample_valid = 1'b0;
    nvm_test_continuous = 1'b0; powerup_done = 1'b0; temp_code = 16'h4000;
    ch1_comp = 16'h0000; ch2_comp = 16'h0000; dac_value = 16'h1000;
    clamp_low = 16'h0100; clamp_high = 16'h7000; field_amp = 16'h01f4;
    lower_field_limit = 16'h0064; upper_field_limit = 16'h03e8;
    rst_val = '{16'h0, 16'h0, FID_LO, FID_HI, 16'h0, 16'h0, 16'h0, 16'h4000, 16'h4000,
                16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    for (int i = 0; i < 16; i++) rd(4'(i), rst_val[i]);
    // Every index written with ones; read-only, reserved and unmapped bits stay put
    for (int i = 0; i < 16; i++) begin
      wr(4'(i), 16'hffff);
      rd(4'(i), (i >= 4 && i <= 14) ? 16'hffff : (i == 1) ? 16'h003f : rst_val[i]);
    end
    chk("programming control", {10'h0, prog_ctrl}, 16'h003f);
    for (int i = 1; i < 15; i++) if (i != 2 && i != 3) wr(4'(i), rst_val[i]);
    // Memory self test counts during power-up only, unless continuous
    @(negedge ref_clk) fault_ev = 5'b00010;
    @(negedge ref_clk) fault_ev = '0;
    rd(`SDT_IDX_FAULT, 16'h0010);
    powerup_done = 1'b1;
    @(negedge ref_clk) fault_ev = 5'b00010;
    @(negedge ref_clk) fault_ev = '0;
    rd(`SDT_IDX_FAULT, 16'h0000);
    nvm_test_continuous = 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk) fault_ev = 5'(1 << i);
      @(negedge ref_clk) fault_ev = '0;
      rd(`SDT_IDX_FAULT, 16'h0008 << i);
      rd(`SDT_IDX_FAULT, 16'h0000);
    end
    for (int i = 0; i < 3; i++) begin
      @(negedge ref_clk) prog_ev = 3'(1 << i);
      @(negedge ref_clk) prog_ev = '0;
      rd(`SDT_IDX_PROGERR, 16'h0100 << i);
      wr(`SDT_IDX_PROGERR, 16'h0100 << i);
      rd(`SDT_IDX_PROGERR, 16'h0000);
    end
    // Clamp levels are inclusive, field limits strict
    @(negedge ref_clk) dac_value = 16'h7000;
    @(negedge ref_clk) dac_value = 16'h0100;
    @(negedge ref_clk) dac_value = 16'h1000;
    rd(`SDT_IDX_FAULT, 16'h0300);
    @(negedge ref_clk) field_amp = 16'h03e8;
    @(negedge ref_clk) field_amp = 16'h0064;
    @(negedge ref_clk) field_amp = 16'h01f4;
    rd(`SDT_IDX_FAULT, 16'h0000);
    @(negedge ref_clk) field_amp = 16'h03e9;
    @(negedge ref_clk) field_amp = 16'h01f4;
    chk("force high clamp", {15'h0, force_high_clamp}, 16'h0001);
    rd(`SDT_IDX_FAULT, 16'h0002);
    chk("force high clamp", {15'h0, force_high_clamp}, 16'h0000);
    @(negedge ref_clk) field_amp = 16'h0063;
    @(negedge ref_clk) field_amp = 16'h01f4;
    rd(`SDT_IDX_FAULT, 16'h0001);
    // Signal path trims
    smp(16'h04d2, 16'hfdc9, 16'h04d2, 16'hfdc9);
    wr(`SDT_IDX_GAIN1, 16'h2000);
    smp(16'h03e8, 16'hfda8, 16'h01f4, 16'hfda8);
    wr(`SDT_IDX_GAIN1, 16'h4000);
    wr(`SDT_IDX_PHASE, 16'h4000);
    smp(16'h03e8, 16'hfda8, 16'h03e8, 16'hff9c);
    // Thirty degrees of phase: channel 2 gain raised by one over the cosine
    wr(`SDT_IDX_GAIN2, 16'h49e7);
    smp(16'h03e8, 16'hfda8, 16'h03e8, 16'hff8c);
    wr(`SDT_IDX_GAIN2, 16'h4000);
    wr(`SDT_IDX_PHASE, 16'h0000);
    wr(`SDT_IDX_COEF_A, 16'h0064);
    wr(`SDT_IDX_COEF_B, 16'h4000);
    wr(`SDT_IDX_COEF_C, 16'h2000);
    wr(`SDT_IDX_OSCALE1, 16'h4000);
    wr(`SDT_IDX_OSCALE2, 16'h7fff);
    smp(16'h03e8, 16'hfda8, 16'h181a, 16'h260b);
    wr(`SDT_IDX_OSCALE1, 16'h0000);
    wr(`SDT_IDX_OSCALE2, 16'h0000);
    // Deadband of 100 codes, stored negative
    wr(`SDT_IDX_DEADBAND, 16'hff9c);
    smp(16'h03e8, 16'hfda8, 16'h03e8, 16'hfda8);
    smp(16'h041a, 16'hfe0c, 16'h03e8, 16'hfda8);
    smp(16'h044d, 16'hfe0d, 16'h044d, 16'hfe0d);
    wr(`SDT_IDX_DEADBAND, 16'h0000);
    smp(16'h044e, 16'hfe0e, 16'h044e, 16'hfe0e);
    print_verdict();
  end
endmodule : sdt_diag_trim_tb_top

`default_nettype wire

/* sdt_map.svh */
// Register indices, field positions, reset values and scaling constants of the
// sensor diagnostics and channel trim block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SDT_MAP_SVH
`define SDT_MAP_SVH

// ==========================================================================
// Register indices on the programming access port
`define SDT_ADDR_W 4
`define SDT_IDX_FAULT 4'h0
`define SDT_IDX_PROGERR 4'h1
`define SDT_IDX_FID_LO 4'h2
`define SDT_IDX_FID_HI 4'h3
`define SDT_IDX_UID_LO 4'h4
`define SDT_IDX_UID_HI 4'h5
`define SDT_IDX_PHASE 4'h6
`define SDT_IDX_GAIN1 4'h7
`define SDT_IDX_GAIN2 4'h8
`define SDT_IDX_COEF_A 4'h9
`define SDT_IDX_COEF_B 4'ha
`define SDT_IDX_COEF_C 4'hb
`define SDT_IDX_OSCALE1 4'hc
`define SDT_IDX_OSCALE2 4'hd
`define SDT_IDX_DEADBAND 4'he

// ==========================================================================
// Fault status fields
`define SDT_FS_CLAMP_HI 9
`define SDT_FS_CLAMP_LO 8
`define SDT_FS_CLIP1 7
`define SDT_FS_CLIP2 6
`define SDT_FS_DSP 5
`define SDT_FS_NVM 4
`define SDT_FS_ROM 3
`define SDT_FS_FIELD_HI 1
`define SDT_FS_FIELD_LO 0
`define SDT_FS_MASK 16'h03fb

// ==========================================================================
// Programming error status fields
`define SDT_PE_PUMP 10
`define SDT_PE_SUPPLY 9
`define SDT_PE_NVRAM 8
`define SDT_PE_CTRL_MASK 16'h003f
`define SDT_PE_FLAG_MASK 16'h0700

// ==========================================================================
// Reset values and fixed-point scaling
`define SDT_ZERO16 16'h0000
`define SDT_GAIN_UNITY 16'h4000
`define SDT_GAIN_SHIFT 14
`define SDT_FRAC_SHIFT 15

`endif

/* sdt_pkg.sv */
// Types shared by the sensor diagnostics and channel trim block.
// Assumes sdt_map.svh sits in the same folder.
`include "sdt_map.svh"

package sdt_pkg;

  // ========================================================================
  // Fault events raised by the self tests and the signal path
  typedef struct packed {
    logic clip1;
    logic clip2;
    logic dsp_fail;
    logic nvm_fail;
    logic rom_parity_fail;
  } sdt_fault_ev_t;

  // ========================================================================
  // Events raised by the memory programming engine
  typedef struct packed {
    logic pump_low;
    logic supply_low;
    logic nvram_fail;
  } sdt_prog_ev_t;

  // ========================================================================
  // One register access from the output-pin programming decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`SDT_ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } sdt_access_t;

endpackage : sdt_pkg

/* sdt_prog_model.sv */
// External programmer that reaches the trim block's registers over the pin decoder port.
// Assumes the block answers every request with a one-cycle acc_ack.
`timescale 1ns/1ps
`default_nettype none

module sdt_prog_model (
  input wire logic ref_clk,
  output var sdt_pkg::sdt_access_t acc,
  input wire logic acc_ack,
  input wire logic [15:0] acc_rdata
);
  initial acc = '0;

  // ======================================================================
  // One register access; requests change only on the falling edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic ok);
    int n;
    @(negedge ref_clk);
    acc = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge ref_clk);
    acc.wr = 1'b0;
    acc.rd = 1'b0;
    // Released data must not look valid, so it is inverted
    acc.wdata = ~d;
    ok = 1'b0;
    // The single acknowledge is checked by the bench through ok; q returns the read data
    for (n = 0; n < 4 && !ok; n++) begin
      if (acc_ack === 1'b1) ok = 1'b1;
      else @(negedge ref_clk);
    end
    q = acc_rdata;
  endtask : xfer
endmodule : sdt_prog_model

`default_nettype wire
